// >>> rtl/dual_comparator_control.sv
// dual comparator digital control: registers, edge events, window mode, flags
// assumes raw comparator outputs arrive async from analog; ahb-lite single master
`timescale 1ns/10ps
`default_nettype none
module dual_comparator_control (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] cmp_raw,
  input wire logic [2:0] vector_ack,
  output dual_comparator_pkg::analog_ctl_t analog0,
  output dual_comparator_pkg::analog_ctl_t analog1,
  output logic [5:0] supply_scale_factor,
  output logic cmp0_pin_drive,
  output logic cmp0_pin_oe,
  output logic [1:0] cmp_level_out,
  output logic [2:0] event_out,
  output logic [1:0] irq_level0,
  output logic [1:0] irq_level1,
  output logic [1:0] irq_level_win
);
  import dual_comparator_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
    edge_hit = 1'b0;
    case (sel)
      edge_toggle: edge_hit = prev ^ now;
      edge_fall: edge_hit = prev & ~now;
      edge_rise: edge_hit = ~prev & now;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic analog_ctl_t decode(input comparator_control_t c,
                                         input comparator_input_select_t m);
    analog_ctl_t a;
    a = '0;
    a.enable = c.enable;
    a.fast = c.fast_select;
    case (c.hyst_select)
      hyst_none: a.hyst_code = 3'b000;
      hyst_small: a.hyst_code = 3'b001;
      hyst_large: a.hyst_code = 3'b010;
      default: a.hyst_code = 3'b000;
    endcase
    if (m.plus_input_select != plus_reserved) begin
      a.plus_onehot = 8'(1) << m.plus_input_select;
    end
    case (m.minus_input_select)
      3'h0: a.minus_onehot = 9'h001;
      3'h1: a.minus_onehot = 9'h002;
      3'h2: a.minus_onehot = 9'h008;
      3'h3: a.minus_onehot = 9'h020;
      3'h4: a.minus_onehot = 9'h080;
      minus_bandgap: a.minus_onehot = 9'h100;
      minus_scaler: a.minus_onehot = 9'h040;
      default: a.minus_onehot = 9'h000;
    endcase
    decode = a;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  comparator_control_t ctl_reg [2];
  comparator_input_select_t mux_reg [2];
  logic [7:0] route_reg;
  logic [7:0] scale_reg;
  logic [7:0] win_reg;
  logic [2:0] flag_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] level_reg;
  logic [1:0] prev_reg;
  cmp_state_t state_reg [2];
  logic [9:0] wait_reg [2];
  logic [1:0] live;
  window_pos_t pos_now;
  window_pos_t pos_reg;
  logic win_on;
  logic win_hit;
  logic [2:0] set_now;
  logic [2:0] clr_now;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wdat;
  logic addr_ok;

  assign wdat = hwdata[7:0];
  assign win_on = win_reg[win_on_bit];
  assign addr_ok = hsel && hready && htrans[1];

  // ---------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
      hrdata <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          ctl0_addr: hrdata[7:0] <= ctl_reg[0];
          ctl1_addr: hrdata[7:0] <= ctl_reg[1];
          mux0_addr: hrdata[7:0] <= mux_reg[0];
          mux1_addr: hrdata[7:0] <= mux_reg[1];
          route_addr: hrdata[7:0] <= route_reg;
          scale_addr: hrdata[7:0] <= scale_reg;
          win_addr: hrdata[7:0] <= win_reg;
          status_addr: hrdata[7:0] <= {pos_reg, level_reg[1], level_reg[0], 1'b0, flag_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // reserved bits are masked so they always read zero, whatever software writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl_reg[0] <= reg_reset;
      ctl_reg[1] <= reg_reset;
      mux_reg[0] <= reg_reset;
      mux_reg[1] <= reg_reset;
      route_reg <= reg_reset;
      scale_reg <= reg_reset;
      win_reg <= reg_reset;
    end else if (clk_en && wr_pend_reg) begin
      case (wr_addr_reg)
        ctl0_addr: ctl_reg[0] <= wdat & ctl_mask;
        ctl1_addr: ctl_reg[1] <= wdat & ctl_mask;
        mux0_addr: mux_reg[0] <= wdat & mux_mask;
        mux1_addr: mux_reg[1] <= wdat & mux_mask;
        route_addr: route_reg <= wdat & route_mask;
        scale_addr: scale_reg <= wdat & scale_mask;
        win_addr: win_reg <= wdat & win_mask;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // comparator levels: sync, then mask while muxes and scaler settle
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 2'b00;
      sync2_reg <= 2'b00;
    end else if (clk_en) begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // a scaler start restarts the long wait even if the other side already uses it
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        state_reg[i] <= st_off;
        wait_reg[i] <= 10'h000;
      end else if (clk_en) begin
        case (state_reg[i])
          st_off: begin
            if (ctl_reg[i].enable) begin
              state_reg[i] <= st_settle;
              wait_reg[i] <= (mux_reg[i].minus_input_select == minus_scaler) ?
                             scaler_start_cyc : mux_settle_cyc;
            end
          end
          st_settle: begin
            if (!ctl_reg[i].enable) begin
              state_reg[i] <= st_off;
            end else if (wait_reg[i] <= 10'h001) begin
              state_reg[i] <= st_run;
            end else begin
              wait_reg[i] <= wait_reg[i] - 10'h001;
            end
          end
          st_run: begin
            if (!ctl_reg[i].enable) begin
              state_reg[i] <= st_off;
            end
          end
          default: state_reg[i] <= st_off;
        endcase
      end
    end
    assign live[i] = (state_reg[i] == st_run);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_reg <= 2'b00;
      prev_reg <= 2'b00;
    end else if (clk_en) begin
      level_reg[0] <= live[0] & sync2_reg[0];
      level_reg[1] <= live[1] & sync2_reg[1];
      prev_reg <= level_reg;
    end
  end

  // ---------------------------------------------------------------
  // window position, events and flags
  // ---------------------------------------------------------------
  always_comb begin
    if (level_reg[0]) begin
      pos_now = pos_above;
    end else if (level_reg[1]) begin
      pos_now = pos_inside;
    end else begin
      pos_now = pos_below;
    end
  end

  always_comb begin
    win_hit = 1'b0;
    if (win_on && (pos_now != pos_reg)) begin
      case (win_reg[3:2])
        2'h0: win_hit = (pos_now == pos_above);
        2'h1: win_hit = (pos_now == pos_inside);
        2'h2: win_hit = (pos_now == pos_below);
        default: win_hit = (pos_now != pos_inside);
      endcase
    end
  end

  always_comb begin
    set_now[cmp0_flag_bit] = edge_hit(ctl_reg[0].edge_select, prev_reg[0], level_reg[0]);
    set_now[cmp1_flag_bit] = edge_hit(ctl_reg[1].edge_select, prev_reg[1], level_reg[1]);
    set_now[win_flag_bit] = win_hit;
    clr_now = vector_ack;
    if (wr_pend_reg && wr_addr_reg == status_addr) begin
      clr_now = clr_now | wdat[2:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_reg <= pos_above;
    end else if (clk_en) begin
      pos_reg <= win_on ? pos_now : pos_above;
    end
  end

  // set wins over a same-cycle clear so no edge is lost
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 3'b000;
      event_out <= 3'b000;
    end else if (clk_en) begin
      flag_reg <= set_now | (flag_reg & ~clr_now);
      event_out <= set_now;
    end
  end

  // ---------------------------------------------------------------
  // outputs to analog, pins and interrupt controller
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      analog0 <= '0;
      analog1 <= '0;
      supply_scale_factor <= 6'h00;
      cmp0_pin_drive <= 1'b0;
      cmp0_pin_oe <= 1'b0;
      cmp_level_out <= 2'b00;
      irq_level0 <= 2'b00;
      irq_level1 <= 2'b00;
      irq_level_win <= 2'b00;
    end else if (clk_en) begin
      analog0 <= decode(ctl_reg[0], mux_reg[0]);
      analog1 <= decode(ctl_reg[1], mux_reg[1]);
      supply_scale_factor <= scale_reg[5:0];
      cmp0_pin_oe <= route_reg[route_bit];
      cmp0_pin_drive <= route_reg[route_bit] & level_reg[0];
      cmp_level_out <= level_reg;
      irq_level0 <= flag_reg[cmp0_flag_bit] ? ctl_reg[0].irq_priority : 2'b00;
      irq_level1 <= flag_reg[cmp1_flag_bit] ? ctl_reg[1].irq_priority : 2'b00;
      irq_level_win <= flag_reg[win_flag_bit] ? win_reg[1:0] : 2'b00;
    end
  end
endmodule
`default_nettype wire

// >>> pkg/dual_comparator_pkg.sv
// package for the dual comparator control block: register map, fields, codes
// assumes one peripheral clock, ahb-lite register access, analog front end outside
//
// Summary of operation
// - comparator level is one when plus input exceeds minus input, else zero.
// - enabled comparator result updates continuously, readable and sent as events.
// - after enable, output may glitch; scaler use adds a longer startup wait.
// - edge event always emitted for the selected edge, interrupt enabled or not.
// - edge select 00 toggle, 01 reserved, 10 falling, 11 rising.
// - control bits 5:4 enable comparator interrupt and set its priority.
// - control bit 3 selects fast mode; clear selects low power.
// - hysteresis bits 2:1 decode none, small, large; 11 reserved.
// - control bit 0 enables the comparator.
// - plus select bits 5:3 route pins 0..6; 111 reserved.
// - minus select: pins 0,1,3,5,7, reserved, bandgap, supply scaler.
// - output route bit drives comparator 0 output on pin 7.
// - scale factor bits 5:0 give supply times factor plus one over 64.
// - window control bit 4 joins both comparators into window mode.
// - window condition decodes above, inside, below, outside.
// - window bits 1:0 enable window interrupt and set its priority.
// - status bits 7:6 give window position above, inside, below.
// - status bits 5 and 4 show comparator 1 and 0 levels.
// - window flag bit 2 set per condition; cleared by vector or write one.
// - comparator 1 flag bit 1 set per edge; cleared by vector or write one.
// - comparator 0 flag bit 0 set per edge; cleared by vector or write one.
package dual_comparator_pkg;
  // register index as in the byte map; each register takes one aligned word
  localparam int ctl0_idx = 0;
  localparam int ctl1_idx = 1;
  localparam int mux0_idx = 2;
  localparam int mux1_idx = 3;
  localparam int route_idx = 4;
  localparam int scale_idx = 5;
  localparam int win_idx = 6;
  localparam int status_idx = 7;
  localparam logic [7:0] ctl0_addr = 8'(4 * ctl0_idx);
  localparam logic [7:0] ctl1_addr = 8'(4 * ctl1_idx);
  localparam logic [7:0] mux0_addr = 8'(4 * mux0_idx);
  localparam logic [7:0] mux1_addr = 8'(4 * mux1_idx);
  localparam logic [7:0] route_addr = 8'(4 * route_idx);
  localparam logic [7:0] scale_addr = 8'(4 * scale_idx);
  localparam logic [7:0] win_addr = 8'(4 * win_idx);
  localparam logic [7:0] status_addr = 8'(4 * status_idx);
  localparam logic [7:0] ctl_mask = 8'hff;
  localparam logic [7:0] mux_mask = 8'h3f;
  localparam logic [7:0] route_mask = 8'h01;
  localparam logic [7:0] scale_mask = 8'h3f;
  localparam logic [7:0] win_mask = 8'h1f;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam int en_bit = 0;
  localparam int fast_bit = 3;
  localparam int route_bit = 0;
  localparam int win_on_bit = 4;
  localparam int cmp0_flag_bit = 0;
  localparam int cmp1_flag_bit = 1;
  localparam int win_flag_bit = 2;
  localparam logic [1:0] edge_toggle = 2'h0;
  localparam logic [1:0] edge_fall = 2'h2;
  localparam logic [1:0] edge_rise = 2'h3;
  localparam logic [1:0] hyst_none = 2'h0;
  localparam logic [1:0] hyst_small = 2'h1;
  localparam logic [1:0] hyst_large = 2'h2;
  localparam logic [2:0] plus_reserved = 3'h7;
  localparam logic [2:0] minus_reserved = 3'h5;
  localparam logic [2:0] minus_bandgap = 3'h6;
  localparam logic [2:0] minus_scaler = 3'h7;
  localparam int scale_den = 64;
  localparam real mux_settle_ns = 100.0;
  localparam real scaler_start_ns = 1000.0;
  localparam real clock_ns = 4.0;
  localparam logic [9:0] mux_settle_cyc = 10'(int'($ceil(mux_settle_ns / clock_ns)));
  localparam logic [9:0] scaler_start_cyc = 10'(int'($ceil(scaler_start_ns / clock_ns)));

  typedef enum logic [1:0] {
    pos_above = 2'b00,
    pos_inside = 2'b01,
    pos_below = 2'b10
  } window_pos_t;

  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_settle = 2'b01,
    st_run = 2'b11
  } cmp_state_t;

  typedef struct packed {
    logic [1:0] edge_select;
    logic [1:0] irq_priority;
    logic fast_select;
    logic [1:0] hyst_select;
    logic enable;
  } comparator_control_t;

  typedef struct packed {
    logic [1:0] unused;
    logic [2:0] plus_input_select;
    logic [2:0] minus_input_select;
  } comparator_input_select_t;

  typedef struct packed {
    logic enable;
    logic fast;
    logic [2:0] hyst_code;
    logic [7:0] plus_onehot;
    logic [8:0] minus_onehot;
  } analog_ctl_t;
endpackage

// >>> dv/dual_comparator_checker.sv
// checker: bus answer, events, interrupt level, settle and follow relations at the ports
// assumes one clock domain; shadows register writes seen on the ahb-lite port
`timescale 1ns/10ps
`default_nettype none
module dual_comparator_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire dual_comparator_pkg::analog_ctl_t analog0,
  input wire logic [5:0] supply_scale_factor,
  input wire logic cmp0_pin_oe,
  input wire logic [1:0] cmp_level_out,
  input wire logic [2:0] event_out,
  input wire logic [1:0] irq_level0
);
  import dual_comparator_pkg::*;
  logic wr_pend;
  logic [7:0] wr_addr, ctl0_sh, route_sh, scale_sh, win_sh;
  // ----------------------------------------
  // write shadow
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl0_sh <= reg_reset;
      route_sh <= reg_reset;
      scale_sh <= reg_reset;
      win_sh <= reg_reset;
    end else if (hready && wr_pend) begin
      case (wr_addr)
        ctl0_addr: ctl0_sh <= hwdata[7:0] & ctl_mask;
        route_addr: route_sh <= hwdata[7:0] & route_mask;
        scale_addr: scale_sh <= hwdata[7:0] & scale_mask;
        win_addr: win_sh <= hwdata[7:0] & win_mask;
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_edge_level: assert property (event_out[0] && ctl0_sh[7] |-> cmp_level_out[0] == ctl0_sh[6])
    else $error("edge event against selected edge");
  a_toggle_event: assert property ($changed(cmp_level_out[0]) && ctl0_sh[7:6] == edge_toggle
    |-> ##[0:1] event_out[0]) else $error("toggle gave no event");
  a_irq_prio: assert property (irq_level0 != 2'h0
    |-> irq_level0 == ctl0_sh[5:4] || irq_level0 == $past(ctl0_sh[5:4]))
    else $error("interrupt level differs from priority");
  a_enable_follow: assert property ($rose(ctl0_sh[en_bit]) |-> ##[0:2] analog0.enable)
    else $error("enable not passed to comparator");
  a_settle_quiet: assert property ($rose(analog0.enable) |-> !cmp_level_out[0] [*8])
    else $error("level not held during settle");
  a_scale_follow: assert property ($changed(scale_sh)
    |-> ##[0:2] supply_scale_factor == scale_sh[5:0]) else $error("scale factor not passed");
  a_route_follow: assert property ($changed(route_sh)
    |-> ##[0:2] cmp0_pin_oe == route_sh[route_bit]) else $error("pin enable not routed");
  a_win_gate: assert property (event_out[2] |-> win_sh[win_on_bit] || $past(win_sh[win_on_bit]))
    else $error("window event with window off");
  c_toggle: cover property (event_out[0] && ctl0_sh[7:6] == edge_toggle);
  c_window: cover property (event_out[2]);
  c_route: cover property (cmp0_pin_oe && cmp_level_out[0]);
endmodule
`default_nettype wire

// >>> dv/analog_front_model.sv
// behavioural analog side: pins, bandgap and supply scaler feeding the comparators
// assumes supply of 1.0, pin high 0.8, low 0.2, bandgap 0.5; no hysteresis or delay
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
  input wire dual_comparator_pkg::analog_ctl_t analog0,
  input wire dual_comparator_pkg::analog_ctl_t analog1,
  input wire logic [5:0] supply_scale_factor,
  input wire logic [7:0] pin_hi,
  output logic [1:0] cmp_raw
);
  import dual_comparator_pkg::*;
  function automatic real pinv(input logic [7:0] sel, input logic [7:0] hi);
    pinv = 0.0;
    for (int i = 0; i < 8; i++) begin
      if (sel[i]) pinv = hi[i] ? 0.8 : 0.2;
    end
  endfunction
  function automatic real negv(input logic [8:0] sel, input logic [7:0] hi, input logic [5:0] f);
    negv = pinv({sel[7], 1'b0, sel[5:0]}, hi);
    if (sel[6]) negv = 1.0 * (f + 1) / scale_den;
    if (sel[8]) negv = 0.5;
  endfunction
  // a disabled comparator idles low, as the real one would
  always_comb begin
    cmp_raw[0] = analog0.enable && (pinv(analog0.plus_onehot, pin_hi)
      > negv(analog0.minus_onehot, pin_hi, supply_scale_factor));
    cmp_raw[1] = analog1.enable && (pinv(analog1.plus_onehot, pin_hi)
      > negv(analog1.minus_onehot, pin_hi, supply_scale_factor));
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// bench: ahb-lite register tasks, comparator, window and pin tests
// assumes checker and analog model beside it; clock 250 MHz
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dual_comparator_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] vector_ack = 3'h0;
  logic [7:0] pin_hi = 8'h00;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cmp0_pin_drive, cmp0_pin_oe;
  logic [1:0] cmp_raw, cmp_level_out, irq_level0, irq_level1, irq_level_win;
  logic [2:0] event_out;
  logic [5:0] supply_scale_factor;
  analog_ctl_t analog0, analog1;
  int err_total = 0;
  int cmp_count = 0;
  int ev [3] = '{0, 0, 0};
  logic [7:0] q;
  logic [7:0] addrs [9] = '{ctl0_addr, ctl1_addr, mux0_addr, mux1_addr, route_addr,
    scale_addr, win_addr, status_addr, 8'h20};
  // status reads below: window is on by then and both comparators sit low
  logic [7:0] masks [9] = '{ctl_mask, ctl_mask, mux_mask, mux_mask, route_mask,
    scale_mask, win_mask, 8'h80, 8'h00};
  logic [8:0] minus_exp [8] = '{9'h001, 9'h002, 9'h008, 9'h020, 9'h080, 9'h000, 9'h100, 9'h040};
  logic [7:0] pins_w [3] = '{8'h05, 8'h04, 8'h00};
  logic [7:0] pos_w [3] = '{8'h00, 8'h40, 8'h80};
  always #2 clock = ~clock;
  dual_comparator_control i_dual_comparator_control (.clock, .nrst, .clk_en(1'b1), .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .cmp_raw, .vector_ack, .analog0, .analog1, .supply_scale_factor, .cmp0_pin_drive,
    .cmp0_pin_oe, .cmp_level_out, .event_out, .irq_level0, .irq_level1, .irq_level_win);
  analog_front_model i_analog_front_model (.analog0, .analog1, .supply_scale_factor, .pin_hi,
    .cmp_raw);
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (event_out[i] === 1'b1) ev[i] <= ev[i] + 1;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic ack(input logic [2:0] v);
    vector_ack <= v;
    cyc(1);
    vector_ack <= 3'h0;
    cyc(2);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    cyc(2);
    nrst <= 1'b1;
    cyc(1);
    for (int i = 0; i < 9; i++) rd(addrs[i], 8'hff, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], 8'hff, masks[i]);
    end
    for (int i = 0; i < 7; i++) wr(addrs[i], 8'h00);
    $display("test register map done");
    for (int i = 0; i < 8; i++) begin
      wr(mux0_addr, {2'b00, i[2:0], i[2:0]});
      cyc(2);
      chk(analog0.plus_onehot, (i == 7) ? 8'h00 : (8'h01 << i));
      chk(analog0.minus_onehot, minus_exp[i]);
    end
    for (int h = 0; h < 3; h++) begin
      wr(ctl1_addr, {4'h0, h[0], h[1:0], 1'b0});
      cyc(2);
      chk({analog1.fast, analog1.hyst_code}, {h[0], 3'(h)});
    end
    wr(scale_addr, 8'h2a);
    cyc(2);
    chk(supply_scale_factor, 6'h2a);
    $display("test decode done");
    wr(mux0_addr, 8'h06);
    wr(route_addr, 8'h01);
    wr(ctl0_addr, 8'h21);
    pin_hi <= 8'h01;
    cyc(10);
    rd(status_addr, 8'h11, 8'h00);
    cyc(40);
    rd(status_addr, 8'hff, 8'h11);
    chk({irq_level0, cmp0_pin_oe, cmp0_pin_drive}, 4'hb);
    ack(3'h1);
    rd(status_addr, 8'hff, 8'h10);
    chk(irq_level0, 2'h0);
    pin_hi <= 8'h00;
    cyc(8);
    rd(status_addr, 8'hff, 8'h01);
    chk(cmp0_pin_drive, 1'b0);
    wr(status_addr, 8'h01);
    rd(status_addr, 8'hff, 8'h00);
    wr(ctl0_addr, 8'he1);
    pin_hi <= 8'h01;
    cyc(8);
    rd(status_addr, 8'hff, 8'h11);
    wr(status_addr, 8'h01);
    pin_hi <= 8'h00;
    cyc(8);
    rd(status_addr, 8'hff, 8'h00);
    chk(ev[0], 3);
    $display("test comparator 0 done");
    wr(scale_addr, 8'h1f);
    wr(mux1_addr, 8'h17);
    pin_hi <= 8'h04;
    wr(ctl1_addr, 8'h81);
    cyc(100);
    rd(status_addr, 8'h20, 8'h00);
    cyc(200);
    rd(status_addr, 8'h22, 8'h20);
    wr(scale_addr, 8'h3f);
    cyc(8);
    rd(status_addr, 8'h22, 8'h02);
    chk(ev[1], 32'd1);
    chk(irq_level1, 2'h0);
    ack(3'h2);
    rd(status_addr, 8'h02, 8'h00);
    $display("test comparator 1 done");
    wr(scale_addr, 8'h1f);
    pin_hi <= 8'h00;
    wr(win_addr, 8'h15);
    cyc(8);
    wr(status_addr, 8'h07);
    for (int i = 0; i < 3; i++) begin
      pin_hi <= pins_w[i];
      cyc(8);
      rd(status_addr, 8'hc0, pos_w[i]);
    end
    rd(status_addr, 8'h04, 8'h04);
    // one window event already came from the switch-on with outside chosen in the map test
    chk(ev[2], 32'd2);
    chk(irq_level_win, 2'h1);
    ack(3'h4);
    rd(status_addr, 8'h04, 8'h00);
    wr(win_addr, 8'h1d);
    pin_hi <= 8'h04;
    cyc(8);
    pin_hi <= 8'h05;
    cyc(8);
    rd(status_addr, 8'h04, 8'h04);
    wr(status_addr, 8'h04);
    rd(status_addr, 8'h04, 8'h00);
    wr(win_addr, 8'h00);
    pin_hi <= 8'h00;
    cyc(8);
    rd(status_addr, 8'hc0, 8'h00);
    $display("test window done");
    conclude();
  end
  initial begin
    cyc(5000);
    err_total++;
    conclude();
  end
endmodule
bind dual_comparator_control dual_comparator_checker i_dual_comparator_checker (.clock, .nrst,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .analog0,
  .supply_scale_factor, .cmp0_pin_oe, .cmp_level_out, .event_out, .irq_level0);
`default_nettype wire
